// >>> core/ppt_defs.svh
`ifndef PPT_DEFS_SVH
`define PPT_DEFS_SVH

// Start control field encodings
`define PPT_START_STOP  2'h0
`define PPT_START_CMD   2'h1
`define PPT_START_RISE  2'h2
`define PPT_START_FALL  2'h3

// Counter and compare width
`define PPT_WIDTH       16

// Default source clock division (one count tick every N clk_in cycles)
`define PPT_SRC_DIV     128

// Reset values
`define PPT_CNT_RST     16'h0000
`define PPT_CMP_RST     16'hFFFF
`define PPT_FF_RST      1'h0

`endif

// >>> core/ppt_pkg.sv
package ppt_pkg;
   // Run state of the timer
   typedef enum logic [1:0] {
      PPT_IDLE,
      PPT_ARMED,
      PPT_RUN
   } ppt_state_t;

   // Operating mode select
   typedef enum logic {
      PPT_MODE_TIMER,
      PPT_MODE_PULSE
   } ppt_mode_t;
endpackage : ppt_pkg

// >>> core/ppt_if.sv
`timescale 1ns/100ps
// Trigger edge events between the pin conditioner and the timer core
interface ppt_edge_if;
   logic rise;   // One-cycle pulse on a rising pin edge
   logic fall;   // One-cycle pulse on a falling pin edge
   modport src (output rise, output fall);
   modport dst (input rise, input fall);
endinterface : ppt_edge_if

// >>> core/ppt_trig.sv
`timescale 1ns/100ps
// Trigger pin conditioner: synchroniser plus edge detector
module ppt_trig (
   input  wire logic clk_in,      // System clock
   input  wire logic rst_in,      // Async reset, active high
   input  wire logic pin_in,      // Raw trigger pin
   ppt_edge_if.src   edge_if      // Edge pulses out
);
   logic sync1_q;  // First stage, read only by second
   logic sync2_q;  // Second stage, safe to use
   logic prev_q;   // Delayed copy for edge detect

   // Two-flop synchroniser and history
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_q <= 1'h0;
         sync2_q <= 1'h0;
         prev_q  <= 1'h0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Edges are one-cycle pulses
   assign edge_if.rise = sync2_q & ~prev_q;
   assign edge_if.fall = ~sync2_q & prev_q;
endmodule : ppt_trig

// >>> core/ppt_top.sv
`timescale 1ns/100ps
`include "ppt_defs.svh"

// How it works
// - Counter and compare registers are 16 bits
// - Counter increments on selected source clock tick
// - Start field picks command or trigger edge
// - Repeat bit: 0 continuous, 1 one-shot
// - Duty match toggles, interrupts, keeps counting
// - Continuous period match toggles, interrupts, clears counter
// - Writing stop halts counter, pin holds level
// - One-shot period match clears start field, stops
// - Pin is complement of the output flip-flop
// - Reset clears the output flip-flop
// - Inverted stop: setting written in pulse mode lands complemented; a timer mode write loads it as written
module ppt_top
   import ppt_pkg::*;
#(
   parameter int SRC_DIV = `PPT_SRC_DIV   // clk_in cycles per count tick
) (
   input  wire logic                   clk_in,          // 25 MHz system clock
   input  wire logic                   rst_in,          // Async reset, active high
   input  wire logic                   trig_pin_in,     // Trigger input pin
   input  wire logic                   ctl_wr_in,       // Control register write strobe
   input  wire logic [1:0]             ctl_start_in,    // Start control field data
   input  wire logic                   ctl_repeat_in,   // Repeat select bit data
   input  wire logic                   ctl_tff_in,      // Initial output setting data
   input  wire ppt_pkg::ppt_mode_t     ctl_mode_in,     // Mode select field data
   input  wire logic                   period_wr_in,    // Period compare write strobe
   input  wire logic                   duty_wr_in,      // Duty compare write strobe
   input  wire logic [`PPT_WIDTH-1:0]  cmp_data_in,     // Compare write data
   output logic                        pulse_out_n_out, // Pulse output pin
   output logic                        timer_match_irq_out, // Match interrupt pulse
   output logic [1:0]                  start_field_out, // Start field readback
   output logic                        running_out,     // Counter is counting
   output logic [`PPT_WIDTH-1:0]       count_out        // Counter readback
);
   import ppt_pkg::*;

   localparam int DIVW = $clog2(SRC_DIV + 1);          // Divider counter width
   localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SRC_DIV - 1);

   ppt_edge_if edge_if ();                             // Trigger edge events

   logic [DIVW-1:0]        div_q;        // Source clock divider
   logic                   tick;         // One-cycle source clock enable
   logic [1:0]             start_q;      // Start control field
   logic                   repeat_q;     // Repeat select bit
   ppt_mode_t              mode_q;       // Mode select field
   ppt_state_t             state_q;      // Run state
   logic                   running_q;    // Registered copy of the run state
   logic [`PPT_WIDTH-1:0]  cnt_q;        // Up-counter
   logic [`PPT_WIDTH-1:0]  period_q;     // Period compare value
   logic [`PPT_WIDTH-1:0]  duty_q;       // Duty compare value
   logic                   ff_q;         // Output flip-flop
   logic                   ff_d;         // Next output flip-flop
   logic                   inv_q;        // Flip-flop inverted from start level
   logic                   irq_q;        // Interrupt pulse register
   logic                   pin_q;        // Pin register
   logic                   duty_hit;     // Duty match on this tick
   logic                   period_hit;   // Period match on this tick
   logic                   trig_hit;     // Selected trigger edge seen
   logic                   pulse_mode;   // Pulse generation selected

   // Pin conditioning lives in its own module
   ppt_trig u_trig (
      .clk_in  (clk_in),
      .rst_in  (rst_in),
      .pin_in  (trig_pin_in),
      .edge_if (edge_if)
   );

   assign pulse_mode = (mode_q == PPT_MODE_PULSE);

   // Source clock divider; free running so ticks stay evenly spaced
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_q <= '0;
      end else if (div_q == DIV_LAST) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + DIVW'(1);
      end
   end
   assign tick = (div_q == DIV_LAST);

   // Compare hits, judged only while running on a tick
   assign duty_hit   = pulse_mode && (state_q == PPT_RUN) && tick && (cnt_q == duty_q);
   assign period_hit = pulse_mode && (state_q == PPT_RUN) && tick && (cnt_q == period_q);

   // Trigger edge chosen by the start field
   assign trig_hit = (start_q == `PPT_START_RISE) ? edge_if.rise :
                     (start_q == `PPT_START_FALL) ? edge_if.fall : 1'h0;

   // Control fields; hardware stop on one-shot end beats a soft write
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_q  <= `PPT_START_STOP;
         repeat_q <= 1'h0;
         mode_q   <= PPT_MODE_TIMER;
      end else begin
         if (ctl_wr_in) begin
            repeat_q <= ctl_repeat_in;
            mode_q   <= ctl_mode_in;
         end
         if (period_hit && repeat_q) begin
            start_q <= `PPT_START_STOP;
         end else if (ctl_wr_in) begin
            start_q <= ctl_start_in;
         end
      end
   end

   // Run state: a write of stop halts at once
   // Run flag kept beside it so the readback leaves straight from a register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q   <= PPT_IDLE;
         running_q <= 1'h0;
      end else if (period_hit && repeat_q) begin
         state_q   <= PPT_IDLE;
         running_q <= 1'h0;
      end else if (ctl_wr_in) begin
         unique case (ctl_start_in)
            `PPT_START_STOP: begin
               state_q   <= PPT_IDLE;
               running_q <= 1'h0;
            end
            `PPT_START_CMD: begin
               state_q   <= PPT_RUN;
               running_q <= 1'h1;
            end
            default: begin
               // Trigger start written while running keeps running
               state_q   <= (state_q == PPT_RUN) ? PPT_RUN : PPT_ARMED;
               running_q <= (state_q == PPT_RUN);
            end
         endcase
      end else if (state_q == PPT_ARMED && trig_hit) begin
         state_q   <= PPT_RUN;
         running_q <= 1'h1;
      end
   end

   // Up-counter; holds its value when stopped
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= `PPT_CNT_RST;
      end else if (period_hit) begin
         cnt_q <= `PPT_CNT_RST;
      end else if (state_q == PPT_RUN && tick) begin
         cnt_q <= cnt_q + `PPT_WIDTH'(1);
      end
   end

   // Compare registers; software keeps period above duty
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         period_q <= `PPT_CMP_RST;
         duty_q   <= `PPT_CMP_RST;
      end else begin
         if (period_wr_in) begin
            period_q <= cmp_data_in;
         end
         if (duty_wr_in) begin
            duty_q <= cmp_data_in;
         end
      end
   end

   // Output flip-flop next value: matches toggle, setup writes load
   always_comb begin
      ff_d = ff_q;
      if (duty_hit || period_hit) begin
         ff_d = ~ff_q;
      end else if (ctl_wr_in && state_q != PPT_RUN) begin
         if (ctl_mode_in == PPT_MODE_TIMER) begin
            ff_d = ctl_tff_in;
         end else begin
            // Stopped inverted, the setting lands complemented
            ff_d = inv_q ? ~ctl_tff_in : ctl_tff_in;
         end
      end
   end

   // Flip-flop, inversion tracker and the pin that mirrors it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ff_q  <= `PPT_FF_RST;
         inv_q <= 1'h0;
         pin_q <= ~`PPT_FF_RST;
      end else begin
         ff_q  <= ff_d;
         pin_q <= ~ff_d;
         if (duty_hit || period_hit) begin
            inv_q <= ~inv_q;
         end else if (ctl_wr_in && ctl_mode_in == PPT_MODE_TIMER) begin
            // Passing through timer mode re-arms a clean start level
            inv_q <= 1'h0;
         end
      end
   end

   // Interrupt pulse, one cycle per match
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_q <= 1'h0;
      end else begin
         irq_q <= duty_hit || period_hit;
      end
   end

   assign pulse_out_n_out     = pin_q;
   assign timer_match_irq_out = irq_q;
   assign start_field_out     = start_q;
   assign running_out         = running_q;
   assign count_out           = cnt_q;

   // Pin always opposite of the flip-flop
   a_pin_complement: assert property (@(posedge clk_in) disable iff (rst_in)
      pulse_out_n_out == ~ff_q) else $error("pin not complement of flip-flop");

   // Interrupt is exactly one cycle wide
   a_irq_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
      irq_q |=> !irq_q) else $error("interrupt wider than one cycle");

   // Match toggles flip-flop and raises interrupt together
   a_match_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
      (duty_hit || period_hit) |=> (irq_q && ff_q != $past(ff_q)))
      else $error("match did not toggle and interrupt");

   // Duty match keeps counting
   a_duty_counts: assert property (@(posedge clk_in) disable iff (rst_in)
      (duty_hit && !period_hit) |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("counter did not advance after duty match");

   // Continuous period match clears counter and stays running
   a_period_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      (period_hit && !repeat_q && !ctl_wr_in) |=> (cnt_q == 16'h0000 && running_out))
      else $error("period match did not clear and continue");

   // One-shot end clears start field and stops
   a_oneshot_stop: assert property (@(posedge clk_in) disable iff (rst_in)
      (period_hit && repeat_q) |=> (start_q == 2'h0 && !running_out))
      else $error("one-shot did not stop");

   // Stopped timer holds count and pin
   a_stop_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      (state_q == PPT_IDLE && !ctl_wr_in) |=> ($stable(cnt_q) && $stable(pulse_out_n_out)))
      else $error("stopped timer changed state");

   // Counter advances only on ticks
   a_count_on_tick: assert property (@(posedge clk_in) disable iff (rst_in)
      (!tick) |=> $stable(cnt_q)) else $error("counter moved without tick");
endmodule : ppt_top

// >>> tb/ppt_load.sv
`timescale 1ns/100ps
// Load on the pulse pin: measures the last low stretch in clocks
module ppt_load (
   input  wire logic        clk_in,      // System clock
   input  wire logic        rst_in,      // Async reset, active high
   input  wire logic        pin_n_in,    // Pulse output pin
   output logic      [15:0] low_len_out  // Length of last low stretch
);
   logic [15:0] run_q;  // Clocks spent low so far
   logic        prev_q; // Pin level one clock ago
   // Count low clocks, latch the total when the pin returns high
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         run_q <= 16'h0000;
         prev_q <= 1'h1;
         low_len_out <= 16'h0000;
      end else begin
         prev_q <= pin_n_in;
         run_q <= pin_n_in ? 16'h0000 : run_q + 16'h0001;
         if (pin_n_in && !prev_q) begin
            low_len_out <= run_q;
         end
      end
   end
endmodule : ppt_load

// >>> tb/programmable_pulse_timer_bench.sv
`timescale 1ns/100ps
`include "ppt_defs.svh"
`define PPT_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module programmable_pulse_timer_bench;
   import ppt_pkg::*;
   localparam int          DIV   = 4;        // Short tick keeps the run brief
   localparam logic [15:0] PER   = 16'h0006; // Period compare
   localparam logic [15:0] DUTY  = 16'h0002; // Duty compare, below period
   localparam logic [15:0] DUTY1 = 16'h0003; // Count just after duty match
   logic clk_in = 1'b0, rst_in = 1'b1, trig_pin_in = 1'b0, ctl_wr_in = 1'b0;
   logic [1:0] ctl_start_in = 2'h0, start_field_out;
   logic ctl_repeat_in = 1'b0, ctl_tff_in = 1'b0, period_wr_in = 1'b0, duty_wr_in = 1'b0;
   ppt_mode_t ctl_mode_in = PPT_MODE_TIMER;
   logic [15:0] cmp_data_in = 16'h0000, count_out, low_len;
   logic pulse_out_n_out, timer_match_irq_out, running_out;
   int fails = 0, n_compared = 0;
   ppt_top #(.SRC_DIV(DIV)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .trig_pin_in(trig_pin_in),
      .ctl_wr_in(ctl_wr_in), .ctl_start_in(ctl_start_in), .ctl_repeat_in(ctl_repeat_in),
      .ctl_tff_in(ctl_tff_in), .ctl_mode_in(ctl_mode_in), .period_wr_in(period_wr_in),
      .duty_wr_in(duty_wr_in), .cmp_data_in(cmp_data_in), .pulse_out_n_out(pulse_out_n_out),
      .timer_match_irq_out(timer_match_irq_out), .start_field_out(start_field_out),
      .running_out(running_out), .count_out(count_out));
   ppt_load u_load (.clk_in(clk_in), .rst_in(rst_in), .pin_n_in(pulse_out_n_out),
      .low_len_out(low_len));
   // Free-running 25 MHz clock
   always #20 clk_in = ~clk_in;
   // Counts, verdict and end of run
   task conclude;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // Control write; one idle edge after it so back-to-back writes never merge
   task ctl(input logic [1:0] s, input logic r, input logic t, input ppt_mode_t m);
      ctl_start_in = s;
      ctl_repeat_in = r;
      ctl_tff_in = t;
      ctl_mode_in = m;
      ctl_wr_in = 1'b1;
      @(negedge clk_in);
      ctl_wr_in = 1'b0;
      @(negedge clk_in);
   endtask : ctl
   // Compare write, whole 16 bits at once, then one idle edge
   task cmp(input logic per, input logic [15:0] v);
      period_wr_in = per;
      duty_wr_in = !per;
      cmp_data_in = v;
      @(negedge clk_in);
      period_wr_in = 1'b0;
      duty_wr_in = 1'b0;
      @(negedge clk_in);
   endtask : cmp
   // Wait for a match pulse, then judge pin, count and pulse length
   task wait_irq(input logic pin, input logic [15:0] cnt, input bit chk_cnt);
      int i;
      i = 0;
      while (timer_match_irq_out !== 1'b1 && i < 200) begin
         @(negedge clk_in);
         i++;
      end
      if (timer_match_irq_out !== 1'b1) begin
         fails++;
         conclude();
      end
      `PPT_CHK(pulse_out_n_out, pin)
      if (chk_cnt) `PPT_CHK(count_out, cnt)
      @(negedge clk_in);
      `PPT_CHK(timer_match_irq_out, 1'b0)
   endtask : wait_irq
   // Wait for the counter to start after a trigger edge
   task wait_run;
      int i;
      i = 0;
      while (running_out !== 1'b1 && i < 20) begin
         @(negedge clk_in);
         i++;
      end
      if (running_out !== 1'b1) begin
         fails++;
         conclude();
      end
      `PPT_CHK(running_out, 1'b1)
   endtask : wait_run
   // Reset levels at the pins
   task t_reset;
      `PPT_CHK(pulse_out_n_out, 1'b1)
      `PPT_CHK({timer_match_irq_out, running_out, start_field_out}, 4'h0)
      `PPT_CHK(count_out, 16'h0000)
      $display("test reset done");
   endtask : t_reset
   // Continuous run by command, then stop with the pin low
   task t_continuous;
      ctl(2'h0, 1'b0, 1'b0, PPT_MODE_PULSE);
      cmp(1'b1, PER);
      cmp(1'b0, DUTY);
      ctl(2'h1, 1'b0, 1'b0, PPT_MODE_PULSE);
      `PPT_CHK(running_out, 1'b1)
      wait_irq(1'b0, DUTY1, 1'b1);
      wait_irq(1'b1, 16'h0000, 1'b1);
      `PPT_CHK(low_len, 16'(DIV * (PER - DUTY)))
      `PPT_CHK(start_field_out, 2'h1)
      wait_irq(1'b0, DUTY1, 1'b1);
      ctl(2'h0, 1'b0, 1'b0, PPT_MODE_PULSE);
      repeat (12) @(negedge clk_in);
      `PPT_CHK({pulse_out_n_out, running_out}, 2'h0)
      `PPT_CHK(count_out, DUTY1)
      $display("test continuous done");
   endtask : t_continuous
   // Setting after an inverted stop, reinit, resume from held count
   task t_reinit;
      ctl(2'h0, 1'b0, 1'b0, PPT_MODE_PULSE);
      `PPT_CHK(pulse_out_n_out, 1'b0)
      ctl(2'h0, 1'b0, 1'b0, PPT_MODE_TIMER);
      `PPT_CHK(pulse_out_n_out, 1'b1)
      ctl(2'h0, 1'b0, 1'b1, PPT_MODE_PULSE);
      `PPT_CHK(pulse_out_n_out, 1'b0)
      ctl(2'h1, 1'b0, 1'b1, PPT_MODE_PULSE);
      wait_irq(1'b1, 16'h0000, 1'b1);
      ctl(2'h0, 1'b0, 1'b1, PPT_MODE_PULSE);
      repeat (8) @(negedge clk_in);
      `PPT_CHK(count_out, 16'h0000)
      $display("test reinit done");
   endtask : t_reinit
   // One-shot started by a rising trigger edge, positive pulse on the pin
   task t_oneshot;
      ctl(2'h0, 1'b0, 1'b1, PPT_MODE_TIMER);
      ctl(2'h2, 1'b1, 1'b1, PPT_MODE_PULSE);
      `PPT_CHK(pulse_out_n_out, 1'b0)
      repeat (10) @(negedge clk_in);
      `PPT_CHK(running_out, 1'b0)
      trig_pin_in = 1'b1;
      wait_run();
      wait_irq(1'b1, DUTY1, 1'b1);
      wait_irq(1'b0, 16'h0000, 1'b1);
      `PPT_CHK({start_field_out, running_out}, 3'h0)
      repeat (12) @(negedge clk_in);
      `PPT_CHK({pulse_out_n_out, running_out}, 2'h0)
      $display("test one-shot done");
   endtask : t_oneshot
   // Falling-edge trigger arms, ignores level, starts on the edge
   task t_falling;
      ctl(2'h3, 1'b0, 1'b1, PPT_MODE_PULSE);
      repeat (6) @(negedge clk_in);
      `PPT_CHK(running_out, 1'b0)
      trig_pin_in = 1'b0;
      wait_run();
      ctl(2'h0, 1'b0, 1'b1, PPT_MODE_PULSE);
      `PPT_CHK(running_out, 1'b0)
      $display("test falling trigger done");
   endtask : t_falling
   // Main sequence
   initial begin
      repeat (5) @(negedge clk_in);
      rst_in = 1'b0;
      t_reset();
      t_continuous();
      t_reinit();
      t_oneshot();
      t_falling();
      conclude();
   end
endmodule : programmable_pulse_timer_bench
